// ---- logic/ismc_top.v ----
// Functional notes
// - Stop begins SDA low, then SCL released.
// - SCL high loads counter, counts to zero.
// - SDA low at counter expiry is collision.
// - SCL low before SDA release is collision.
// - Mask register shares reload address, slave-mask mode.
// - Slave mode: control two bits 5:1 mask.
// - Halt trigger bit starts the stop sequence.
// - Collision sets flag, port logic goes idle.
// - Collision releases lines, clears trigger bits except the receive trigger.
// - Stop seen sets status; later event flag.
`timescale 1ns/1ps
`default_nettype none
`include "ismc_regs.vh"

module ismc_top #(
  parameter RW = 7
) (
  // Clock and reset
  input wire clk_i,
  input wire nrst_i,
  // APB slave
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [11:0] paddr_i,
  input wire [31:0] pwdata_i,
  output reg [31:0] prdata_o,
  output reg pready_o,
  output reg pslverr_o,
  // Two-wire bus, open drain
  input wire scl_i,
  output reg scl_o,
  output reg scl_oe_o,
  input wire sda_i,
  output reg sda_o,
  output reg sda_oe_o,
  // Interrupt
  output reg irq_o
);

  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_SDA_LOW = 3'h1;
  localparam [2:0] ST_SCL_WAIT = 3'h2;
  localparam [2:0] ST_COUNT_HI = 3'h3;
  localparam [2:0] ST_SDA_REL = 3'h4;
  localparam [2:0] ST_TAIL = 3'h5;

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and bus monitor.

  wire [1:0] lines_s;
  wire scl_s;
  wire sda_s;
  reg scl_prev_q;
  reg sda_prev_q;

  ismc_sync #(
    .W(2)
  ) u_sync (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .async_i({scl_i, sda_i}),
    .sync_o(lines_s)
  );

  assign scl_s = lines_s[1];
  assign sda_s = lines_s[0];

  always @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end
    else
    begin
      scl_prev_q <= scl_s;
      sda_prev_q <= sda_s;
    end
  end

  wire start_seen = scl_s && scl_prev_q && sda_prev_q && !sda_s;
  wire stop_seen = scl_s && scl_prev_q && !sda_prev_q && sda_s;

  ////////////////////////////////////////////////////////////////////////////////
  // Registers and APB decode.

  reg [7:0] shift_buffer_reg_q;
  reg [7:0] address_or_reload_reg_q;
  reg [7:0] address_mask_reg_q;
  reg [7:0] control_one_reg_q;
  reg [7:0] control_two_reg_q;
  reg [4:0] mask_bits_q;
  reg stop_det_q;
  reg start_det_q;
  reg buffer_full_flag_q;
  reg [1:0] int_status_q;
  reg [1:0] int_mask_q;
  reg [2:0] state_q;
  reg [2:0] state_d;
  reg [31:0] rdata_d;
  reg hit_d;

  function is_slave;
    input [3:0] mode;
    begin
      is_slave = (mode != `ISMC_MODE_MASTER);
    end
  endfunction

  wire [3:0] mode = control_one_reg_q[`ISMC_C1_MODE_HI:`ISMC_C1_MODE_LO];
  wire enabled = control_one_reg_q[`ISMC_C1_ENABLE];
  wire slave = is_slave(mode);
  wire mask_view = (mode == `ISMC_MODE_SLV7_MASK);
  wire access_cyc = psel_i && penable_i && !pready_o;
  wire wr_en = psel_i && penable_i && pready_o && pwrite_i && !pslverr_o;
  wire wr_buf = wr_en && (paddr_i == `ISMC_OFS_SHIFT_BUF);
  wire wr_addr = wr_en && (paddr_i == `ISMC_OFS_ADDR_RELOAD);
  wire wr_c1 = wr_en && (paddr_i == `ISMC_OFS_CTRL_ONE);
  wire wr_c2 = wr_en && (paddr_i == `ISMC_OFS_CTRL_TWO);
  wire wr_ist = wr_en && (paddr_i == `ISMC_OFS_INT_STATUS);
  wire wr_imask = wr_en && (paddr_i == `ISMC_OFS_INT_MASK);
  wire stop_busy = (state_q != ST_IDLE);

  always @*
  begin
    rdata_d = 32'h0000_0000;
    hit_d = 1'b1;
    case (paddr_i)
      `ISMC_OFS_SHIFT_BUF:
      begin
        rdata_d[7:0] = shift_buffer_reg_q;
      end
      `ISMC_OFS_ADDR_RELOAD:
      begin
        rdata_d[7:0] = mask_view ? address_mask_reg_q : address_or_reload_reg_q;
      end
      `ISMC_OFS_CTRL_ONE:
      begin
        rdata_d[7:0] = control_one_reg_q;
      end
      `ISMC_OFS_CTRL_TWO:
      begin
        rdata_d[7:0] = control_two_reg_q;
        if (is_slave(mode))
        begin
          rdata_d[`ISMC_C2_MASK_HI:`ISMC_C2_MASK_LO] = mask_bits_q;
        end
      end
      `ISMC_OFS_STATUS:
      begin
        rdata_d[`ISMC_ST_STOP] = stop_det_q;
        rdata_d[`ISMC_ST_START] = start_det_q;
        rdata_d[`ISMC_ST_FULL] = buffer_full_flag_q;
      end
      `ISMC_OFS_INT_STATUS:
      begin
        rdata_d[1:0] = int_status_q;
      end
      `ISMC_OFS_INT_MASK:
      begin
        rdata_d[1:0] = int_mask_q;
      end
      default:
      begin
        hit_d = 1'b0;
      end
    endcase
  end

  // One wait state: the answer is registered on the first access cycle.
  always @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h0000_0000;
    end
    else
    begin
      pready_o <= access_cyc;
      pslverr_o <= access_cyc && !hit_d;
      if (access_cyc && !pwrite_i)
      begin
        prdata_o <= rdata_d;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Baud reload counter and stop sequence.

  reg baud_load;
  reg coll_d;
  reg done_d;
  reg stop_set_d;
  wire baud_expired;

  ismc_baud #(
    .W(RW)
  ) u_baud (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .load_i(baud_load),
    .stop_i(coll_d || !enabled),
    .reload_i(address_or_reload_reg_q[`ISMC_RELOAD_HI:`ISMC_RELOAD_LO]),
    .expired_o(baud_expired)
  );

  wire halt_req = control_two_reg_q[`ISMC_C2_HALT_TRIG] && enabled && !slave;

  always @*
  begin
    state_d = state_q;
    baud_load = 1'b0;
    coll_d = 1'b0;
    done_d = 1'b0;
    stop_set_d = 1'b0;
    case (state_q)
      ST_IDLE:
      begin
        if (halt_req)
        begin
          state_d = ST_SDA_LOW;
        end
      end
      ST_SDA_LOW:
      begin
        if (!sda_s)
        begin
          state_d = ST_SCL_WAIT;
        end
      end
      ST_SCL_WAIT:
      begin
        if (scl_s)
        begin
          baud_load = 1'b1;
          state_d = ST_COUNT_HI;
        end
      end
      ST_COUNT_HI:
      begin
        if (!scl_s)
        begin
          coll_d = 1'b1;
        end
        else if (baud_expired)
        begin
          baud_load = 1'b1;
          state_d = ST_SDA_REL;
        end
      end
      ST_SDA_REL:
      begin
        if (sda_s && scl_s)
        begin
          stop_set_d = 1'b1;
        end
        if (baud_expired)
        begin
          if (!sda_s)
          begin
            coll_d = 1'b1;
          end
          else
          begin
            baud_load = 1'b1;
            state_d = ST_TAIL;
          end
        end
      end
      ST_TAIL:
      begin
        if (baud_expired)
        begin
          done_d = 1'b1;
          state_d = ST_IDLE;
        end
      end
      default:
      begin
        state_d = ST_IDLE;
      end
    endcase
    if (coll_d || !enabled)
    begin
      state_d = ST_IDLE;
    end
  end

  always @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      state_q <= ST_IDLE;
      scl_oe_o <= 1'b0;
      sda_oe_o <= 1'b0;
      scl_o <= 1'b0;
      sda_o <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      scl_o <= 1'b0;
      sda_o <= 1'b0;
      if (coll_d || !enabled)
      begin
        scl_oe_o <= 1'b0;
        sda_oe_o <= 1'b0;
      end
      else
      begin
        case (state_d)
          ST_SDA_LOW:
          begin
            scl_oe_o <= 1'b1;
            sda_oe_o <= 1'b1;
          end
          ST_SCL_WAIT, ST_COUNT_HI:
          begin
            scl_oe_o <= 1'b0;
            sda_oe_o <= 1'b1;
          end
          default:
          begin
            scl_oe_o <= 1'b0;
            sda_oe_o <= 1'b0;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Register writes and hardware updates.

  always @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      shift_buffer_reg_q <= `ISMC_RST_BYTE;
      address_or_reload_reg_q <= `ISMC_RST_BYTE;
      address_mask_reg_q <= `ISMC_RST_BYTE;
      control_one_reg_q <= `ISMC_RST_BYTE;
      control_two_reg_q <= `ISMC_RST_BYTE;
      mask_bits_q <= `ISMC_RST_MASK_BITS;
      stop_det_q <= 1'b0;
      start_det_q <= 1'b0;
      buffer_full_flag_q <= 1'b0;
      int_status_q <= `ISMC_RST_INT;
      int_mask_q <= `ISMC_RST_INT;
      irq_o <= 1'b0;
    end
    else
    begin
      // A buffer write during the stop sequence is dropped and flagged.
      if (wr_buf && !stop_busy)
      begin
        shift_buffer_reg_q <= pwdata_i[7:0];
      end
      if (wr_addr && mask_view)
      begin
        address_mask_reg_q <= pwdata_i[7:0];
      end
      else if (wr_addr)
      begin
        address_or_reload_reg_q <= pwdata_i[7:0];
      end
      if (wr_c1)
      begin
        control_one_reg_q <= pwdata_i[7:0];
      end
      if (wr_buf && stop_busy)
      begin
        control_one_reg_q[`ISMC_C1_WRCOL] <= 1'b1;
      end
      if (wr_c2)
      begin
        control_two_reg_q[`ISMC_C2_GCALL] <= pwdata_i[`ISMC_C2_GCALL];
        control_two_reg_q[`ISMC_C2_BEGIN_TRIG] <= pwdata_i[`ISMC_C2_BEGIN_TRIG];
        if (slave)
        begin
          mask_bits_q <= pwdata_i[`ISMC_C2_MASK_HI:`ISMC_C2_MASK_LO];
        end
        else
        begin
          control_two_reg_q[`ISMC_C2_MASK_HI:`ISMC_C2_MASK_LO] <=
            pwdata_i[`ISMC_C2_MASK_HI:`ISMC_C2_MASK_LO];
        end
      end
      if (coll_d)
      begin
        control_two_reg_q[`ISMC_C2_BEGIN_TRIG] <= 1'b0;
        control_two_reg_q[`ISMC_C2_REP_TRIG] <= 1'b0;
        control_two_reg_q[`ISMC_C2_HALT_TRIG] <= 1'b0;
        control_two_reg_q[`ISMC_C2_ACK_TRIG] <= 1'b0;
      end
      if (done_d)
      begin
        control_two_reg_q[`ISMC_C2_HALT_TRIG] <= 1'b0;
      end
      // Bus monitor for start and stop, cleared while disabled.
      if (!enabled)
      begin
        stop_det_q <= 1'b0;
        start_det_q <= 1'b0;
      end
      else if (stop_set_d || stop_seen)
      begin
        stop_det_q <= 1'b1;
        start_det_q <= 1'b0;
      end
      else if (start_seen)
      begin
        start_det_q <= 1'b1;
        stop_det_q <= 1'b0;
      end
      if (coll_d)
      begin
        buffer_full_flag_q <= 1'b0;
      end
      // Sticky events: a set in the same cycle beats a clear.
      int_status_q[`ISMC_INT_EVENT] <=
        (int_status_q[`ISMC_INT_EVENT] && !(wr_ist && pwdata_i[`ISMC_INT_EVENT])) || done_d;
      int_status_q[`ISMC_INT_COLL] <=
        (int_status_q[`ISMC_INT_COLL] && !(wr_ist && pwdata_i[`ISMC_INT_COLL])) || coll_d;
      if (wr_imask)
      begin
        int_mask_q <= pwdata_i[1:0];
      end
      irq_o <= |(int_status_q & int_mask_q);
    end
  end

endmodule // ismc_top

`default_nettype wire

// ---- logic/ismc_regs.vh ----
`ifndef ISMC_REGS_VH
`define ISMC_REGS_VH

// Register byte offsets on the APB bus.
`define ISMC_OFS_SHIFT_BUF 12'h000
`define ISMC_OFS_ADDR_RELOAD 12'h004
`define ISMC_OFS_CTRL_ONE 12'h008
`define ISMC_OFS_CTRL_TWO 12'h00c
`define ISMC_OFS_STATUS 12'h010
`define ISMC_OFS_INT_STATUS 12'h014
`define ISMC_OFS_INT_MASK 12'h018

// Reset values.
`define ISMC_RST_BYTE 8'h00
`define ISMC_RST_INT 2'h0
`define ISMC_RST_MASK_BITS 5'h00

// Control one fields.
`define ISMC_C1_WRCOL 7
`define ISMC_C1_OVFL 6
`define ISMC_C1_ENABLE 5
`define ISMC_C1_CLK_REL 4
`define ISMC_C1_MODE_HI 3
`define ISMC_C1_MODE_LO 0

// Mode codes in control one bits 3:0.
`define ISMC_MODE_MASTER 4'h8
`define ISMC_MODE_SLV7 4'h6
`define ISMC_MODE_SLV10 4'h7
`define ISMC_MODE_SLV7_MASK 4'h9

// Control two fields.
`define ISMC_C2_GCALL 7
`define ISMC_C2_ACK_RX 6
`define ISMC_C2_ACK_VAL 5
`define ISMC_C2_ACK_TRIG 4
`define ISMC_C2_RX_TRIG 3
`define ISMC_C2_HALT_TRIG 2
`define ISMC_C2_REP_TRIG 1
`define ISMC_C2_BEGIN_TRIG 0
`define ISMC_C2_MASK_HI 5
`define ISMC_C2_MASK_LO 1

// Serial status fields.
`define ISMC_ST_STOP 4
`define ISMC_ST_START 3
`define ISMC_ST_FULL 0

// Interrupt status and mask fields.
`define ISMC_INT_EVENT 0
`define ISMC_INT_COLL 1

// Reload field of the address/reload register.
`define ISMC_RELOAD_HI 6
`define ISMC_RELOAD_LO 0

`endif

// ---- logic/ismc_sync.v ----
`timescale 1ns/1ps
`default_nettype none

module ismc_sync #(
  parameter W = 2
) (
  // Clock and reset
  input wire clk_i,
  input wire nrst_i,
  // Data
  input wire [W-1:0] async_i,
  output wire [W-1:0] sync_o
);

  reg [W-1:0] meta_q;
  reg [W-1:0] sync_q;

  // Idle bus lines float high, so the stages reset high.
  always @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      meta_q <= {W{1'b1}};
      sync_q <= {W{1'b1}};
    end
    else
    begin
      meta_q <= async_i;
      sync_q <= meta_q;
    end
  end

  assign sync_o = sync_q;

endmodule // ismc_sync

`default_nettype wire

// ---- logic/ismc_baud.v ----
`timescale 1ns/1ps
`default_nettype none

module ismc_baud #(
  parameter W = 7
) (
  // Clock and reset
  input wire clk_i,
  input wire nrst_i,
  // Control
  input wire load_i,
  input wire stop_i,
  input wire [W-1:0] reload_i,
  // Status
  output reg expired_o
);

  reg [W-1:0] count_q;
  reg run_q;

  // Counts down from the reload value; one pulse when zero is reached.
  always @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      count_q <= {W{1'b0}};
      run_q <= 1'b0;
      expired_o <= 1'b0;
    end
    else
    begin
      expired_o <= 1'b0;
      if (stop_i)
      begin
        run_q <= 1'b0;
      end
      else if (load_i)
      begin
        count_q <= reload_i;
        run_q <= 1'b1;
      end
      else if (run_q)
      begin
        if (count_q == {W{1'b0}})
        begin
          run_q <= 1'b0;
          expired_o <= 1'b1;
        end
        else
        begin
          count_q <= count_q - {{(W-1){1'b0}}, 1'b1};
        end
      end
    end
  end

endmodule // ismc_baud

`default_nettype wire

// ---- bench/ismc_checker_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none

module ismc_checker (
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Register bus
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pready_o,
  input wire logic pslverr_o,
  // Two-wire pins
  input wire logic scl_i,
  input wire logic scl_o,
  input wire logic scl_oe_o,
  input wire logic sda_o,
  input wire logic sda_oe_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!nrst_i);

  a_ready_wait: assert property ($rose(penable_i) && psel_i |=> pready_o)
    else $error("pready not one cycle after access");
  a_ready_pulse: assert property (pready_o |=> !pready_o)
    else $error("pready longer than one cycle");
  a_ready_access: assert property (pready_o |-> psel_i && penable_i)
    else $error("pready outside access phase");
  a_err_ready: assert property (pslverr_o |-> pready_o)
    else $error("pslverr without pready");
  a_pins_low: assert property (!scl_o && !sda_o)
    else $error("open-drain data not low");
  a_sda_first: assert property ($fell(scl_oe_o) && !$fell(sda_oe_o) |-> sda_oe_o)
    else $error("clock released while data not held low");
  a_sda_last: assert property ($fell(sda_oe_o) |-> !scl_oe_o)
    else $error("data released before clock");
  a_scl_coll: assert property (!scl_oe_o && sda_oe_o && $fell(scl_i) |-> ##[1:6] !sda_oe_o)
    else $error("clock pulled low without abort");
endmodule // ismc_checker

bind ismc_top ismc_checker chk_u (.clk_i(clk_i), .nrst_i(nrst_i), .psel_i(psel_i),
  .penable_i(penable_i), .pready_o(pready_o), .pslverr_o(pslverr_o), .scl_i(scl_i),
  .scl_o(scl_o), .scl_oe_o(scl_oe_o), .sda_o(sda_o), .sda_oe_o(sda_oe_o));

`default_nettype wire

// ---- bench/ismc_bus_model.sv ----
`timescale 1ns/1ps
`default_nettype none

module ismc_bus_model (
  // Pull-downs from the device
  input wire logic scl_oe_i,
  input wire logic sda_oe_i,
  // Pull-downs from another master or a stretching slave
  input wire logic hold_scl_i,
  input wire logic hold_sda_i,
  // Resolved line levels
  output logic scl_o,
  output logic sda_o
);
  // Both lines have pull-ups, so a released line reads high.
  assign scl_o = !(scl_oe_i || hold_scl_i);
  assign sda_o = !(sda_oe_i || hold_sda_i);
endmodule // ismc_bus_model

`default_nettype wire

// ---- bench/tb_i2c_master_stop_collision_detect.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "ismc_regs.vh"

module tb_i2c_master_stop_collision_detect;
  logic clk_i, nrst_i, psel_i, penable_i, pwrite_i, hold_scl, hold_sda, e;
  logic [11:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o, r;
  logic pready_o, pslverr_o, scl_i, scl_o, scl_oe_o, sda_i, sda_o, sda_oe_o, irq_o;
  int fail_count = 0;
  int check_count = 0;
  int cyc = 0;
  int n3, n10, ns;

  ismc_top #(.RW(7)) dut_u (.clk_i(clk_i), .nrst_i(nrst_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .scl_i(scl_i),
    .scl_o(scl_o), .scl_oe_o(scl_oe_o), .sda_i(sda_i), .sda_o(sda_o),
    .sda_oe_o(sda_oe_o), .irq_o(irq_o));
  ismc_bus_model bus_u (.scl_oe_i(scl_oe_o), .sda_oe_i(sda_oe_o), .hold_scl_i(hold_scl),
    .hold_sda_i(hold_sda), .scl_o(scl_i), .sda_o(sda_i));

  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  task report_and_stop;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  always @(posedge clk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      fail_count++;
      report_and_stop();
    end
  end

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    // Poll on the falling edge, where the registered answer has settled.
    @(negedge clk_i);
    while (pready_o !== 1'b1) @(negedge clk_i);
    r = prdata_o;
    e = pslverr_o;
    @(posedge clk_i);
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
      fail_count++;
    end
  endtask

  task rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(r, exp);
  endtask

  task fin(input string s);
    $display("test %s done, checks %0d", s, check_count);
  endtask

  // Kinds: 0 clean, 1 data held low, 2 clock pulled low, 3 clock stretched.
  task run_stop(input int kind, output int n);
    hold_sda <= (kind == 1);
    hold_scl <= (kind == 3);
    apb(1'b1, `ISMC_OFS_CTRL_TWO, 32'h4);
    @(negedge clk_i);
    while (!sda_oe_o) @(negedge clk_i);
    while (scl_oe_o) @(negedge clk_i);
    n = 0;
    if (kind == 2)
    begin
      repeat (3) @(posedge clk_i);
      hold_scl <= 1'b1;
    end
    if (kind == 3)
    begin
      // A buffer write while the stop sequence runs must be refused.
      @(posedge clk_i);
      apb(1'b1, `ISMC_OFS_SHIFT_BUF, 32'h55);
      repeat (15) @(posedge clk_i);
      hold_scl <= 1'b0;
    end
    while (!irq_o)
    begin
      @(negedge clk_i);
      n++;
    end
  endtask

  task settle;
    hold_scl <= 1'b0;
    hold_sda <= 1'b0;
    repeat (8) @(posedge clk_i);
    apb(1'b1, `ISMC_OFS_INT_STATUS, 32'h3);
  endtask

  initial
  begin
    {psel_i, penable_i, pwrite_i, hold_scl, hold_sda, nrst_i} = '0;
    paddr_i = '0;
    pwdata_i = '0;
    repeat (4) @(posedge clk_i);
    nrst_i <= 1'b1;
    @(posedge clk_i);
    rd(`ISMC_OFS_CTRL_ONE, 32'h0);
    apb(1'b1, `ISMC_OFS_INT_MASK, 32'h3);
    apb(1'b1, `ISMC_OFS_CTRL_ONE, 32'h28);
    apb(1'b1, `ISMC_OFS_ADDR_RELOAD, 32'h83);
    apb(1'b1, `ISMC_OFS_CTRL_ONE, 32'h29);
    apb(1'b1, `ISMC_OFS_ADDR_RELOAD, 32'h5a);
    rd(`ISMC_OFS_ADDR_RELOAD, 32'h5a);
    apb(1'b1, `ISMC_OFS_CTRL_ONE, 32'h26);
    apb(1'b1, `ISMC_OFS_CTRL_TWO, 32'h3e);
    rd(`ISMC_OFS_CTRL_TWO, 32'h3e);
    apb(1'b1, `ISMC_OFS_CTRL_ONE, 32'h28);
    rd(`ISMC_OFS_ADDR_RELOAD, 32'h83);
    rd(`ISMC_OFS_CTRL_TWO, 32'h0);
    chk(sda_oe_o, 1'b0);
    fin("slave views");
    run_stop(0, n3);
    rd(`ISMC_OFS_INT_STATUS, 32'h1);
    rd(`ISMC_OFS_STATUS, 32'h10);
    rd(`ISMC_OFS_CTRL_TWO, 32'h0);
    settle();
    rd(`ISMC_OFS_INT_STATUS, 32'h0);
    apb(1'b1, `ISMC_OFS_ADDR_RELOAD, 32'h0a);
    run_stop(0, n10);
    chk(32'(n10 - n3), 32'd21);
    settle();
    fin("clean stop");
    run_stop(1, ns);
    chk({sda_oe_o, scl_oe_o}, 2'b00);
    rd(`ISMC_OFS_INT_STATUS, 32'h2);
    rd(`ISMC_OFS_CTRL_TWO, 32'h0);
    apb(1'b1, `ISMC_OFS_INT_MASK, 32'h0);
    repeat (2) @(posedge clk_i);
    chk(irq_o, 1'b0);
    apb(1'b1, `ISMC_OFS_INT_MASK, 32'h3);
    repeat (2) @(posedge clk_i);
    chk(irq_o, 1'b1);
    settle();
    fin("data collision");
    run_stop(2, ns);
    rd(`ISMC_OFS_INT_STATUS, 32'h2);
    rd(`ISMC_OFS_CTRL_TWO, 32'h0);
    settle();
    fin("clock collision");
    run_stop(3, ns);
    rd(`ISMC_OFS_INT_STATUS, 32'h1);
    rd(`ISMC_OFS_CTRL_ONE, 32'ha8);
    rd(`ISMC_OFS_SHIFT_BUF, 32'h0);
    apb(1'b1, `ISMC_OFS_CTRL_ONE, 32'h28);
    settle();
    fin("stretch");
    apb(1'b0, 12'h01c, 32'h0);
    chk(e, 1'b1);
    chk(r, 32'h0);
    fin("unmapped");
    report_and_stop();
  end
endmodule // tb_i2c_master_stop_collision_detect

`default_nettype wire
